// [hps_pkg.sv]
/*
 * Shared constants and carrier types for the home-preset sequencer.
 * Assumes a single 50 MHz system clock and a control-power reset.
 */
package hps_pkg;
    // Clock and time base
    localparam int CLK_FREQ_MHZ = 50;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = TICK_TIME_US * CLK_FREQ_MHZ;

    // Sequence windows, in milliseconds (one tick each)
    localparam int HOLD_TIME_MS = 1000;
    localparam int WINDOW_TIME_MS = 3000;
    localparam int BLINK_HALF_MS = 250;
    localparam int SHOW_TIME_MS = 500;
    localparam int MS_W = 16;

    // Shaft position width and reset value
    localparam int POS_W = 32;
    localparam logic [POS_W-1:0] HOME_RESET = 32'h0000_0000;

    typedef enum {
        HPS_IDLE,
        HPS_HOLD,
        HPS_WAIT_RELEASE,
        HPS_WAIT_PRESS,
        HPS_CONFIRM,
        HPS_LOCKOUT
    } hps_state_e;

    typedef struct packed {
        logic red;
        logic green;
    } hps_indicator_s;

    typedef struct packed {
        logic req;
        logic [POS_W-1:0] data;
    } hps_nvm_write_s;
endpackage

// [hps_tick_gen.sv]
/*
 * Divider that gives a one-cycle enable pulse every DIV clock cycles.
 * Assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module hps_tick_gen #(
    parameter int DIV = 50000
) (
    input wire logic core_clk, // System clock
    input wire logic reset_n,  // Async reset, active low
    output logic tick          // One-cycle pulse every DIV cycles
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            tick <= 1'b0;
        end else if (count == LAST) begin
            count <= '0;
            tick <= 1'b1;
        end else begin
            count <= count + CW'(1);
            tick <= 1'b0;
        end
    end
endmodule // hps_tick_gen

`default_nettype wire

// [hps_sequencer.sv]
/*
 * Front-panel home-preset sequencer: times hold, release and re-press of
 * the home button, drives the power/alarm indicator and captures home.
 * Assumes the button input is debounced and synchronous to core_clk, and
 * that the non-volatile store presents its saved home after reset.
 */
// Overview of operation
// - Home is undefined until a stored or newly completed home exists.
// - A completed home is written once to non-volatile storage.
// - Holding the button one second starts red and green blinking.
// - Timely re-press shows red and green, then green, and sets home.
// - Either window over three seconds aborts to steady green; hold again.
// - Home is the shaft position present when the sequence completes.
// - Return-to-home may also set home; that path lies outside here.
`timescale 1ns/100ps
`default_nettype none

module hps_sequencer #(
    parameter int TICK_DIV = hps_pkg::TICK_CYCLES
) (
    input wire logic core_clk,                             // System clock
    input wire logic reset_n,                              // Async reset, active low
    input wire logic home_button,                          // Button pressed, high
    input wire logic [hps_pkg::POS_W-1:0] shaft_position,  // Present shaft position
    input wire logic stored_home_valid,                    // Store holds a home
    input wire logic [hps_pkg::POS_W-1:0] stored_home,     // Home held in store
    output hps_pkg::hps_indicator_s power_alarm_indicator, // Two-colour lamp
    output hps_pkg::hps_nvm_write_s nvm_write,             // Store write pulse
    output logic home_valid,                               // Home defined
    output logic [hps_pkg::POS_W-1:0] home_position        // Home coordinate
);
    import hps_pkg::*;

    localparam logic [MS_W-1:0] HOLD_MS = MS_W'(HOLD_TIME_MS);
    localparam logic [MS_W-1:0] WIN_MS = MS_W'(WINDOW_TIME_MS);
    localparam logic [MS_W-1:0] BLINK_MS = MS_W'(BLINK_HALF_MS);
    localparam logic [MS_W-1:0] SHOW_MS = MS_W'(SHOW_TIME_MS);

    hps_state_e state;
    hps_state_e next_state;
    logic tick;
    logic [MS_W-1:0] ms_count;
    logic [MS_W-1:0] blink_count;
    logic blink_on;
    logic boot_done;
    logic confirm_now;
    hps_indicator_s next_indicator;

    hps_tick_gen #(
        .DIV(TICK_DIV)
    ) u_tick (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .tick(tick)
    );

    always_comb begin
        next_state = state;
        case (state)
            HPS_IDLE: begin
                if (home_button) begin
                    next_state = HPS_HOLD;
                end
            end
            HPS_HOLD: begin
                if (!home_button) begin
                    next_state = HPS_IDLE;
                end else if (ms_count >= HOLD_MS) begin
                    next_state = HPS_WAIT_RELEASE;
                end
            end
            HPS_WAIT_RELEASE: begin
                if (!home_button) begin
                    next_state = HPS_WAIT_PRESS;
                end else if (ms_count >= WIN_MS) begin
                    next_state = HPS_LOCKOUT;
                end
            end
            HPS_WAIT_PRESS: begin
                if (home_button) begin
                    next_state = HPS_CONFIRM;
                end else if (ms_count >= WIN_MS) begin
                    next_state = HPS_LOCKOUT;
                end
            end
            HPS_CONFIRM: begin
                if (ms_count >= SHOW_MS) begin
                    next_state = HPS_LOCKOUT;
                end
            end
            HPS_LOCKOUT: begin
                // A still-held button must not start a new hold
                if (!home_button) begin
                    next_state = HPS_IDLE;
                end
            end
            default: begin
                next_state = HPS_IDLE;
            end
        endcase
    end

    assign confirm_now = (state == HPS_WAIT_PRESS) && home_button;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= HPS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Window timer restarts on every state change
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_count <= '0;
        end else if (next_state != state) begin
            ms_count <= '0;
        end else if (tick && ms_count != '1) begin
            ms_count <= ms_count + MS_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            blink_count <= '0;
            blink_on <= 1'b1;
        end else if (state == HPS_HOLD) begin
            blink_count <= '0;
            blink_on <= 1'b1;
        end else if (tick) begin
            if (blink_count >= BLINK_MS - MS_W'(1)) begin
                blink_count <= '0;
                blink_on <= ~blink_on;
            end else begin
                blink_count <= blink_count + MS_W'(1);
            end
        end
    end

    always_comb begin
        next_indicator = '{red: 1'b0, green: 1'b1};
        case (next_state)
            HPS_WAIT_RELEASE, HPS_WAIT_PRESS: begin
                next_indicator = '{red: blink_on, green: blink_on};
            end
            HPS_CONFIRM: begin
                next_indicator = '{red: 1'b1, green: 1'b1};
            end
            default: begin
                next_indicator = '{red: 1'b0, green: 1'b1};
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            power_alarm_indicator <= '{red: 1'b0, green: 1'b1};
        end else begin
            power_alarm_indicator <= next_indicator;
        end
    end

    // Stored home is taken on the first edge after reset release
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_done <= 1'b0;
            home_valid <= 1'b0;
            home_position <= HOME_RESET;
        end else if (!boot_done) begin
            boot_done <= 1'b1;
            home_valid <= stored_home_valid;
            // Store may also hold a home set by the return-to-home path
            home_position <= stored_home;
        end else if (confirm_now) begin
            home_valid <= 1'b1;
            home_position <= shaft_position;
        end
    end

    // One write per completed sequence keeps store wear low
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            nvm_write <= '{req: 1'b0, data: HOME_RESET};
        end else if (boot_done && confirm_now) begin
            nvm_write <= '{req: 1'b1, data: shaft_position};
        end else begin
            nvm_write.req <= 1'b0;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    a_write_sets_home: assert property (
        nvm_write.req |-> home_valid && home_position == nvm_write.data)
        else $error("store write without matching home");

    a_capture_shaft: assert property (
        nvm_write.req |-> nvm_write.data == $past(shaft_position))
        else $error("home not taken from shaft position");

    a_write_cause: assert property (
        nvm_write.req |-> $past(state == HPS_WAIT_PRESS && home_button) ##1 !nvm_write.req)
        else $error("store write without confirming press");

    a_hold_to_blink: assert property (
        state == HPS_HOLD && home_button && ms_count >= HOLD_MS
        |=> state == HPS_WAIT_RELEASE && power_alarm_indicator.red == blink_on)
        else $error("hold did not start blinking");

    a_early_release: assert property (
        state == HPS_HOLD && !home_button
        |=> state == HPS_IDLE && !power_alarm_indicator.red && $stable(home_position))
        else $error("early release not discarded");

    a_release_timeout: assert property (
        state == HPS_WAIT_RELEASE && home_button && ms_count >= WIN_MS
        |=> state == HPS_LOCKOUT && power_alarm_indicator == '{red: 1'b0, green: 1'b1})
        else $error("release window did not abort");

    a_press_timeout: assert property (
        state == HPS_WAIT_PRESS && !home_button && ms_count >= WIN_MS
        |=> state == HPS_LOCKOUT ##1 (state == HPS_IDLE || home_button))
        else $error("press window did not abort");

    a_confirm_lamp: assert property (
        state == HPS_CONFIRM && ms_count >= SHOW_MS
        |-> power_alarm_indicator.red && power_alarm_indicator.green
            ##1 !power_alarm_indicator.red && power_alarm_indicator.green)
        else $error("confirm did not show both then green");

    a_home_stable: assert property (
        boot_done && $past(boot_done) && !nvm_write.req |-> $stable(home_position))
        else $error("home changed without a completed sequence");
endmodule // hps_sequencer

`default_nettype wire

// [hps_operator.sv]
/*
 * Operator model: presses and releases the home button on command.
 * Assumes the bench calls act() and that core_clk runs throughout.
 */
`timescale 1ns/100ps
`default_nettype none

module hps_operator (
    input wire logic core_clk, // System clock
    output logic home_button   // Button pressed, high
);
    initial home_button = 1'b0;

    // Level stands n cycles; changed on the falling edge, away from sampling
    task automatic act(input logic level, input int n);
        @(negedge core_clk);
        home_button = level;
        repeat (n - 1) @(negedge core_clk);
    endtask
endmodule // hps_operator
`default_nettype wire

// [home_preset_button_sequencer_tb.sv]
/*
 * Self-checking bench for the home-preset sequencer, tick of 4 cycles.
 * Assumes the operator model in hps_operator.sv drives the button.
 */
`timescale 1ns/100ps
`default_nettype none

module home_preset_button_sequencer_tb;
    import hps_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic home_button;
    logic [POS_W-1:0] shaft_position = 32'h0000_0000;
    logic stored_home_valid = 1'b0;
    logic [POS_W-1:0] stored_home = 32'h0000_0000;
    hps_indicator_s power_alarm_indicator;
    hps_nvm_write_s nvm_write;
    logic home_valid;
    logic [POS_W-1:0] home_position;
    logic [POS_W:0] exp_home = 33'h0_0000_0000;
    int failures = 0;
    int comparisons = 0;
    int writes = 0;
    int cycles = 0;

    hps_operator u_hps_operator (.core_clk(core_clk), .home_button(home_button));
    hps_sequencer #(.TICK_DIV(4)) u_hps_sequencer (
        .core_clk(core_clk), .reset_n(reset_n), .home_button(home_button),
        .shaft_position(shaft_position), .stored_home_valid(stored_home_valid),
        .stored_home(stored_home), .power_alarm_indicator(power_alarm_indicator),
        .nvm_write(nvm_write), .home_valid(home_valid), .home_position(home_position));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // Sampled away from the launching edge so the pulse has settled
    always @(negedge core_clk) begin
        cycles++;
        if (nvm_write.req === 1'b1) writes++;
        if (cycles == 95000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check_lamp(input hps_indicator_s exp);
        comparisons++;
        if (power_alarm_indicator !== exp) begin
            failures++;
            $display("wrong value at %0t: lamp %b", $time, power_alarm_indicator);
        end
    endtask

    task automatic check_word(input logic [POS_W:0] got, input logic [POS_W:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Full sequence; rel and gap keep both waits inside the windows
    task automatic preset(input int rel, input int gap);
        logic [POS_W-1:0] pos;
        pos = $urandom;
        shaft_position = ~pos;
        u_hps_operator.act(1'b1, 3990);
        check_lamp(2'h1);
        u_hps_operator.act(1'b1, 40 + rel);
        check_lamp(2'h3);
        u_hps_operator.act(1'b0, gap);
        u_hps_operator.act(1'b1, 1);
        shaft_position = pos;
        @(negedge core_clk);
        shaft_position = $urandom;
        exp_home = {1'b1, pos};
        check_lamp(2'h3);
        check_word(nvm_write, exp_home);
        check_word({home_valid, home_position}, exp_home);
        @(negedge core_clk);
        check_word(nvm_write, {1'b0, pos});
        repeat (2100) @(negedge core_clk);
        check_lamp(2'h1);
        u_hps_operator.act(1'b0, 5);
    endtask

    // Overrun one window, then a short fresh press must not count
    task automatic abort(input bit late_press);
        if (late_press) begin
            u_hps_operator.act(1'b1, 4100);
            u_hps_operator.act(1'b0, 12100);
        end else begin
            // Early in the release window the blink is in its dark half
            u_hps_operator.act(1'b1, 5501);
            check_lamp(2'h0);
            u_hps_operator.act(1'b1, 10699);
        end
        check_lamp(2'h1);
        check_word({home_valid, home_position}, exp_home);
        u_hps_operator.act(1'b0, 5);
        u_hps_operator.act(1'b1, 200);
        check_lamp(2'h1);
        u_hps_operator.act(1'b0, 5);
        check_word({home_valid, home_position}, exp_home);
    endtask

    initial begin
        void'($urandom(32'h37de0fb5));
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        check_word({home_valid, home_position}, 33'h0_0000_0000);
        check_lamp(2'h1);
        preset(1, 1);
        abort(1'b0);
        abort(1'b1);
        // Power cycle: the saved home must come back
        stored_home_valid = 1'b1;
        stored_home = $urandom;
        reset_n = 1'b0;
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        exp_home = {1'b1, stored_home};
        check_word({home_valid, home_position}, exp_home);
        for (int i = 0; i < 2; i++) begin
            preset($urandom_range(900, 1), $urandom_range(8000, 1));
        end
        check_word(33'(writes), 33'h0_0000_0003);
        stop_test();
    end
endmodule // home_preset_button_sequencer_tb
`default_nettype wire
